// file: verilog/fsf_pkg.sv
package fsf_pkg;

  // register byte offsets
  localparam logic [7:0] FSF_OFS_STATUS  = 8'h00;
  localparam logic [7:0] FSF_OFS_CONTROL = 8'h04;
  localparam logic [7:0] FSF_OFS_MODE    = 8'h08;
  localparam logic [7:0] FSF_OFS_FIFOCTL = 8'h0c;
  localparam logic [7:0] FSF_OFS_TXPORT  = 8'h10;
  localparam logic [7:0] FSF_OFS_RXPORT  = 8'h14;

  // status word layout
  localparam int FSF_ST_ERRCNT_LSB = 8;
  localparam int FSF_ST_RXFAULT    = 7;
  localparam int FSF_ST_TXDONE     = 6;
  localparam int FSF_ST_TXLOW      = 5;
  localparam int FSF_ST_FRAMING    = 3;
  localparam int FSF_ST_PARITY     = 2;
  localparam logic [15:0] FSF_STATUS_RST = 16'h0060;

  // control, mode and fifo control fields
  localparam int FSF_CTL_TX_ON      = 5;
  localparam int FSF_CTL_RX_ON      = 4;
  localparam int FSF_MODE_PAR_ODD   = 0;
  localparam int FSF_MODE_PAR_EN    = 1;
  localparam int FSF_MODE_TWO_STOP  = 2;
  localparam int FSF_FCR_TTRG_LSB   = 4;
  localparam logic [7:0] FSF_CTL_RST  = 8'h00;
  localparam logic [7:0] FSF_MODE_RST = 8'h00;
  localparam logic [7:0] FSF_FCR_RST  = 8'h00;

  // transmit trigger levels selected by the two trigger bits
  localparam logic [4:0] FSF_TTRG_L0 = 5'h08;
  localparam logic [4:0] FSF_TTRG_L1 = 5'h04;
  localparam logic [4:0] FSF_TTRG_L2 = 5'h02;
  localparam logic [4:0] FSF_TTRG_L3 = 5'h01;

  localparam int FSF_TX_DEPTH = 16;
  localparam int FSF_RX_DEPTH = 16;

endpackage

// file: verilog/fsf_rx_fifo.sv
`timescale 1ns/1ns
module fsf_rx_fifo
  import fsf_pkg::*;
#(
  parameter int DEPTH = FSF_RX_DEPTH,
  parameter int AW    = 4
)(
  input  wire logic       pclk,        // peripheral clock
  input  wire logic       presetn,     // async reset, active low
  input  wire logic       flush,       // standby: empty the fifo
  input  wire logic       in_valid,    // received character strobe
  input  wire logic [7:0] in_data,     // received data bits
  input  wire logic       in_parity,   // received parity bit
  input  wire logic       in_stop1,    // first sampled stop bit
  input  wire logic       parity_en,   // parity checking on
  input  wire logic       parity_odd,  // odd parity selected
  input  wire logic       pop,         // software read of rx port
  output logic      [7:0] out_data,    // character at the fifo head
  output logic            out_fer,     // framing fault of last read
  output logic            out_per,     // parity fault of last read
  output logic            err_event,   // errored character accepted
  output logic      [7:0] err_count    // errored entries held
);

  logic [9:0]  mem_q [DEPTH];
  logic [AW:0] cnt_q, cnt_d;
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [7:0]  ec_q, ec_d;
  logic        fer_q, fer_d, per_q, per_d;
  logic        fe, pe, push, pop_ok;
  logic [9:0]  head;

  // an empty fifo shows zero rather than stale storage
  assign out_data  = (cnt_q != '0) ? head[7:0] : 8'h00;
  assign out_fer   = fer_q;
  assign out_per   = per_q;
  assign err_count = ec_q;
  assign head      = mem_q[rp_q];

  // only the first stop bit is looked at; a second one is never sampled
  assign fe = ~in_stop1;
  assign pe = parity_en & ((^{in_data, in_parity}) != parity_odd);
  // errored characters still enter the fifo; a full fifo drops the char
  assign push      = in_valid & (cnt_q != (AW+1)'(DEPTH));
  assign pop_ok    = pop & (cnt_q != '0);
  assign err_event = push & (fe | pe);

  // pointer, count and read-out next values
  always_comb
  begin
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    ec_d  = ec_q;
    fer_d = fer_q;
    per_d = per_q;
    if (push)
    begin
      wp_d = wp_q + 1'b1;
    end
    if (pop_ok)
    begin
      rp_d  = rp_q + 1'b1;
      fer_d = head[8];
      per_d = head[9];
    end
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop_ok);
    ec_d  = ec_q + 8'(err_event) - 8'(pop_ok & (head[8] | head[9]));
    if (flush)
    begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
      ec_d  = '0;
      fer_d = 1'b0;
      per_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
      ec_q  <= 8'h00;
      fer_q <= 1'b0;
      per_q <= 1'b0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      ec_q  <= ec_d;
      fer_q <= fer_d;
      per_q <= per_d;
    end
  end

  // storage has no reset; entries are only read after being written
  always_ff @(posedge pclk)
  begin
    if (push)
    begin
      mem_q[wp_q] <= {pe, fe, in_data};
    end
  end

endmodule

// file: verilog/fsf_status.sv
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module fsf_status
  import fsf_pkg::*;
#(
  parameter int TX_DEPTH = FSF_TX_DEPTH
)(
  input  wire logic        pclk,           // peripheral clock
  input  wire logic        presetn,        // async reset, active low
  input  wire logic        standby,        // standby entry level
  input  wire logic        module_standby, // module standby level
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb access phase
  input  wire logic        pwrite,         // apb write
  input  wire logic [7:0]  paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic      [31:0] prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb error on unmapped
  input  wire logic        rx_char_valid,  // received character strobe
  input  wire logic [7:0]  rx_char_data,   // received data bits
  input  wire logic        rx_char_parity, // received parity bit
  input  wire logic        rx_char_stop1,  // first sampled stop bit
  input  wire logic        tx_shift_load,  // shifter took a byte
  input  wire logic        tx_last_bit,    // last bit of a char sent
  output logic             tx_push,        // byte written to tx fifo
  output logic      [7:0]  tx_push_data,   // that byte
  output logic             rx_enable,      // rx_on_bit of control word
  output logic             tx_enable       // tx_on_bit of control word
);

  localparam logic [4:0] TXD = 5'(TX_DEPTH);

  logic        stby;
  logic        setup, access, wr, rd, mapped;
  logic        wr_ctl, wr_mode, wr_fcr, rd_status;
  logic [31:0] rdat_d, rdat_q;
  logic [7:0]  ctl_q, ctl_d, mode_q, mode_d, fcr_q, fcr_d;
  logic        er_q, er_d, tx_finished_flag_q, tx_finished_flag_d, tx_fifo_low_flag_q, tx_fifo_low_flag_d;
  logic [2:0]  seen_q, seen_d;
  logic [4:0]  txc_q, txc_d, bud_q, bud_d, trig;
  logic        txp_q, txp_d;
  logic [7:0]  txb_q, txb_d;
  logic        tx_wr, tx_ok, pop_ok, er_set, tx_finished_flag_set, tx_fifo_low_flag_set, tx_fifo_low_flag_clr;
  logic [2:0]  clr0;
  logic [15:0] status;
  logic [7:0]  rx_byte, err_cnt;
  logic        rx_fer, rx_per, rx_err;

  assign stby    = standby | module_standby;
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign wr      = access & pwrite;
  assign rd      = access & ~pwrite;
  // register decodes shared by the next-value logic below
  assign wr_ctl    = wr & (paddr == FSF_OFS_CONTROL);
  assign wr_mode   = wr & (paddr == FSF_OFS_MODE);
  assign wr_fcr    = wr & (paddr == FSF_OFS_FIFOCTL);
  assign rd_status = rd & (paddr == FSF_OFS_STATUS);
  assign pready  = 1'b1;
  assign prdata  = rdat_q;
  assign mapped  = paddr inside {FSF_OFS_STATUS, FSF_OFS_CONTROL, FSF_OFS_MODE,
                                 FSF_OFS_FIFOCTL, FSF_OFS_TXPORT, FSF_OFS_RXPORT};
  assign pslverr = access & ~mapped;
  assign rx_enable    = ctl_q[FSF_CTL_RX_ON];
  assign tx_enable    = ctl_q[FSF_CTL_TX_ON];
  assign tx_push      = txp_q;
  assign tx_push_data = txb_q;

  // count of errored entries above, flags below
  assign status = {err_cnt, er_q, tx_finished_flag_q, tx_fifo_low_flag_q, 1'b0, rx_fer, rx_per, 2'b00};

  // receive fifo; reading the rx port pops it
  fsf_rx_fifo #(
    .DEPTH (FSF_RX_DEPTH),
    .AW    (4)
  ) u_rx (
    .pclk       (pclk),
    .presetn    (presetn),
    .flush      (stby),
    .in_valid   (rx_char_valid & ctl_q[FSF_CTL_RX_ON]),
    .in_data    (rx_char_data),
    .in_parity  (rx_char_parity),
    .in_stop1   (rx_char_stop1),
    .parity_en  (mode_q[FSF_MODE_PAR_EN]),
    .parity_odd (mode_q[FSF_MODE_PAR_ODD]),
    .pop        (rd & (paddr == FSF_OFS_RXPORT)),
    .out_data   (rx_byte),
    .out_fer    (rx_fer),
    .out_per    (rx_per),
    .err_event  (rx_err),
    .err_count  (err_cnt)
  );

  // trigger level from the two trigger bits
  always_comb
  begin
    case (fcr_q[FSF_FCR_TTRG_LSB +: 2])
      2'd0:    trig = FSF_TTRG_L0;
      2'd1:    trig = FSF_TTRG_L1;
      2'd2:    trig = FSF_TTRG_L2;
      default: trig = FSF_TTRG_L3;
    endcase
  end

  // transmit fifo bookkeeping; full or out of budget writes are dropped
  assign tx_wr  = wr & (paddr == FSF_OFS_TXPORT);
  assign tx_ok  = tx_wr & (txc_q != TXD) & ~(tx_fifo_low_flag_q & (bud_q == 5'h00));
  assign pop_ok = tx_shift_load & (txc_q != 5'h00);

  // flag events
  assign er_set   = rx_err;
  assign tx_finished_flag_set = (tx_last_bit & (txc_q == 5'h00)) |
                    (ctl_q[FSF_CTL_TX_ON] & ~ctl_d[FSF_CTL_TX_ON]);
  assign tx_fifo_low_flag_set = pop_ok & (txc_q == trig);
  assign tx_fifo_low_flag_clr = tx_ok & (txc_d > trig);

  // a 0 written to a flag that was seen as 1 since its last set
  always_comb
  begin
    clr0 = 3'b000;
    if (wr && (paddr == FSF_OFS_STATUS))
    begin
      clr0 = ~pwdata[FSF_ST_RXFAULT:FSF_ST_TXLOW] & seen_q;
    end
  end

  // control, mode and fifo control words; standby resets only the control word
  always_comb
  begin
    ctl_d  = ctl_q;
    mode_d = mode_q;
    fcr_d  = fcr_q;
    if (wr_ctl)
    begin
      ctl_d = pwdata[7:0];
    end
    if (wr_mode)
    begin
      mode_d = pwdata[7:0];
    end
    if (wr_fcr)
    begin
      fcr_d = pwdata[7:0];
    end
    if (stby)
    begin
      ctl_d = FSF_CTL_RST;
    end
  end

  // the trigger choice survives standby, so software need not restore it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_q  <= FSF_CTL_RST;
      mode_q <= FSF_MODE_RST;
      fcr_q  <= FSF_FCR_RST;
    end
    else
    begin
      ctl_q  <= ctl_d;
      mode_q <= mode_d;
      fcr_q  <= fcr_d;
    end
  end

  // transmit count, write budget and the byte pushed towards the shifter
  always_comb
  begin
    txc_d = txc_q + 5'(tx_ok) - 5'(pop_ok);
    bud_d = bud_q;
    if (tx_ok && tx_fifo_low_flag_q)
    begin
      bud_d = bud_q - 5'h01;
    end
    // the budget restarts whenever the low flag sets afresh
    if (tx_fifo_low_flag_set)
    begin
      bud_d = TXD - trig;
    end
    txp_d = tx_ok;
    txb_d = tx_ok ? pwdata[7:0] : txb_q;
    // standby empties the count but keeps the trigger, so reload from it
    if (stby)
    begin
      txc_d = 5'h00;
      bud_d = TXD - trig;
      txp_d = 1'b0;
    end
  end

  // the push byte keeps its last value; only the pulse qualifies it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      txc_q <= 5'h00;
      bud_q <= TXD - FSF_TTRG_L0;
      txp_q <= 1'b0;
      txb_q <= 8'h00;
    end
    else
    begin
      txc_q <= txc_d;
      bud_q <= bud_d;
      txp_q <= txp_d;
      txb_q <= txb_d;
    end
  end

  // flag next values; a set beats a same-cycle clear
  always_comb
  begin
    // receiver enable plays no part here, so turning it off keeps the flag
    er_d   = er_set | (er_q & ~clr0[2]);
    tx_finished_flag_d = tx_finished_flag_set | (tx_finished_flag_q & ~clr0[1] & ~tx_ok);
    tx_fifo_low_flag_d = tx_fifo_low_flag_set | (tx_fifo_low_flag_q & ~clr0[0] & ~tx_fifo_low_flag_clr);
    seen_d = seen_q & ~clr0;
    if (rd_status)
    begin
      // only a 1 that the bus really returned arms the clear
      seen_d = seen_d | (rdat_q[FSF_ST_RXFAULT:FSF_ST_TXLOW] & {er_q, tx_finished_flag_q, tx_fifo_low_flag_q});
    end
    // a fresh set needs a fresh read before a clear counts
    seen_d = seen_d & ~{er_set, tx_finished_flag_set, tx_fifo_low_flag_set};
    if (stby)
    begin
      er_d   = FSF_STATUS_RST[FSF_ST_RXFAULT];
      tx_finished_flag_d = FSF_STATUS_RST[FSF_ST_TXDONE];
      tx_fifo_low_flag_d = FSF_STATUS_RST[FSF_ST_TXLOW];
      seen_d = 3'b000;
    end
  end

  // seen bits clear when the flags reset so a reset never arms a clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      er_q   <= FSF_STATUS_RST[FSF_ST_RXFAULT];
      tx_finished_flag_q <= FSF_STATUS_RST[FSF_ST_TXDONE];
      tx_fifo_low_flag_q <= FSF_STATUS_RST[FSF_ST_TXLOW];
      seen_q <= 3'b000;
    end
    else
    begin
      er_q   <= er_d;
      tx_finished_flag_q <= tx_finished_flag_d;
      tx_fifo_low_flag_q <= tx_fifo_low_flag_d;
      seen_q <= seen_d;
    end
  end

  // read data captured in setup so it stands through the access phase
  // limitation: a char that lands in an empty rx fifo during setup is popped unseen
  always_comb
  begin
    rdat_d = rdat_q;
    if (setup)
    begin
      case (paddr)
        FSF_OFS_STATUS:  rdat_d = {16'h0000, status};
        FSF_OFS_CONTROL: rdat_d = {24'h000000, ctl_q};
        FSF_OFS_MODE:    rdat_d = {24'h000000, mode_q};
        FSF_OFS_FIFOCTL: rdat_d = {24'h000000, fcr_q};
        FSF_OFS_TXPORT:  rdat_d = {27'h0000000, txc_q};
        FSF_OFS_RXPORT:  rdat_d = {24'h000000, rx_byte}; // head of the rx fifo
        default:         rdat_d = 32'h00000000;
      endcase
    end
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdat_q <= 32'h00000000;
    end
    else
    begin
      rdat_q <= rdat_d;
    end
  end

endmodule

// file: testbench/fsf_status_monitor.sv
`timescale 1ns/1ns
module fsf_status_monitor
  import fsf_pkg::*;
(
  input wire logic        pclk,           // clock
  input wire logic        presetn,        // reset
  input wire logic        standby,        // standby
  input wire logic        module_standby, // standby
  input wire logic        psel,           // apb
  input wire logic        penable,        // apb
  input wire logic        pwrite,         // apb
  input wire logic [7:0]  paddr,          // apb
  input wire logic [31:0] pwdata,         // apb
  input wire logic [31:0] prdata,         // apb
  input wire logic        rx_char_valid,  // frame
  input wire logic        rx_char_stop1,  // stop bit
  input wire logic        tx_last_bit,    // last bit
  input wire logic        tx_push,        // push
  input wire logic [7:0]  tx_push_data,   // push byte
  input wire logic        rx_enable,      // rx on
  input wire logic        tx_enable       // tx on
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // bus phases decoded once; prdata is captured at the end of setup
  wire logic rd_st = psel && !penable && !pwrite && paddr == FSF_OFS_STATUS;
  wire logic rd_tx = psel && !penable && !pwrite && paddr == FSF_OFS_TXPORT;
  wire logic wr_tx = psel && penable && pwrite && paddr == FSF_OFS_TXPORT;
  wire logic wr_ct = psel && penable && pwrite && paddr == FSF_OFS_CONTROL;
  wire logic awake = !standby && !module_standby;
  sequence bad_frame;
    rx_char_valid && rx_enable && !rx_char_stop1 && awake;
  endsequence
  a_word_upper: assert property (rd_st |=> prdata[31:16] == 16'h0000)
    else $error("status upper half not zero");
  a_standby_word: assert property ((standby || module_standby) ##1 (rd_st && awake) |=> prdata == 32'h0060)
    else $error("standby did not restore status");
  a_fault_sets: assert property (bad_frame ##1 (rd_st && awake) |=> prdata[FSF_ST_RXFAULT])
    else $error("bad stop bit left fault clear");
  a_fault_counts: assert property (bad_frame ##1 (rd_st && awake) |=> prdata[15:8] != 8'h00)
    else $error("bad frame not counted");
  a_push_cause: assert property (tx_push |-> $past(wr_tx) && tx_push_data == $past(pwdata[7:0]))
    else $error("push without matching write");
  a_ctl_follow: assert property (wr_ct && awake |=> rx_enable == $past(pwdata[FSF_CTL_RX_ON]))
    else $error("receiver enable wrong");
  a_done_clear: assert property (tx_push && rd_st && !tx_last_bit && awake |=> !prdata[FSF_ST_TXDONE])
    else $error("write left transmit done set");
  a_count_bound: assert property (rd_tx |=> prdata <= 32'h10)
    else $error("transmit count above depth");
  c_fault_read: cover property (bad_frame ##1 rd_st);
  c_push_pair: cover property (tx_push ##2 tx_push);
  c_standby: cover property (standby ##1 rd_st);
  c_tx_off: cover property (wr_ct ##1 !tx_enable);
endmodule
bind fsf_status fsf_status_monitor mon (
  .pclk(pclk), .presetn(presetn), .standby(standby), .module_standby(module_standby), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .rx_char_valid(rx_char_valid), .rx_char_stop1(rx_char_stop1), .tx_last_bit(tx_last_bit),
  .tx_push(tx_push), .tx_push_data(tx_push_data), .rx_enable(rx_enable), .tx_enable(tx_enable));

// file: testbench/fsf_remote_peer.sv
`timescale 1ns/1ns
module fsf_remote_peer
  import fsf_pkg::*;
(
  input  wire logic       pclk,   // clock
  output logic            valid,  // frame strobe
  output logic      [7:0] data,   // frame data
  output logic            par,    // parity bit
  output logic            stop1,  // first stop bit
  output logic            load,   // shifter takes byte
  output logic            last    // last bit out
);
  initial
  begin
    valid = 1'b0;
    data = 8'h00;
    par = 1'b0;
    stop1 = 1'b1;
    load = 1'b0;
    last = 1'b0;
  end
  // only the first stop bit is shown; each frame is followed by at least one idle cycle
  task automatic send(input logic [7:0] d, input logic p, input logic s);
    @(posedge pclk);
    valid <= 1'b1;
    data <= d;
    par <= p;
    stop1 <= s;
    @(posedge pclk);
    valid <= 1'b0;
    data <= ~d; // idle lines must not echo the frame
    par <= ~p;
    stop1 <= ~s;
  endtask
  // shifter takes a byte; gap sets a prompt or slow line
  task automatic shift(input int gap);
    @(posedge pclk);
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    repeat (gap) @(posedge pclk);
    last <= 1'b1;
    @(posedge pclk);
    last <= 1'b0;
  endtask
endmodule

// file: testbench/test_fifo_uart_status_flags.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("BAD %0t %h %h", $time, a, b); end end
module test_fifo_uart_status_flags
  import fsf_pkg::*;
;
  logic        pclk = 1'b0, presetn = 1'b0, standby = 1'b0, module_standby = 1'b0, anyf;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, rxv, rxp, rxs, tsl, tlb;
  logic [7:0]  paddr = 8'h00, rxd, nerr;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0]  flt [8];
  logic [7:0]  rxb [8];
  logic        pslverr, err, txe, rxe;
  logic [2:0]  md;
  logic [15:0] lfsr = 16'h0001;
  int          failures = 0, n_tests = 0, tl;
  bit          chain = 1'b0;
  always #4 pclk = ~pclk;
  fsf_status uut (.pclk(pclk), .presetn(presetn), .standby(standby), .module_standby(module_standby),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_char_valid(rxv), .rx_char_data(rxd), .rx_char_parity(rxp),
    .rx_char_stop1(rxs), .tx_shift_load(tsl), .tx_last_bit(tlb), .tx_push(), .tx_push_data(),
    .rx_enable(rxe), .tx_enable(txe));
  fsf_remote_peer p (.pclk(pclk), .valid(rxv), .data(rxd), .par(rxp), .stop1(rxs), .load(tsl), .last(tlb));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // framing and parity fault expected for one frame
  function automatic logic [1:0] fault(input logic [7:0] d, input logic p, s, input logic [2:0] m);
    return {~s, m[FSF_MODE_PAR_EN] & ((^{d, p}) != m[FSF_MODE_PAR_ODD])};
  endfunction
  // keep holds psel so the next setup follows at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input bit keep = 1'b0);
    if (!chain)
      @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
    if (!keep)
      psel <= 1'b0;
    chain = keep;
  endtask
  task automatic results();
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // clear before any read, write ones, poke read-only and unmapped
    apb(1'b1, FSF_OFS_STATUS, 32'h0);
    apb(1'b0, FSF_OFS_STATUS, 32'h0);
    `CHK(rd, 32'h0060)
    `CHK(err, 1'b0)
    apb(1'b1, FSF_OFS_STATUS, 32'hffff_ffbf);
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(err, 1'b1)
    apb(1'b0, FSF_OFS_STATUS, 32'h0);
    `CHK(rd, 32'h0020)
    apb(1'b1, FSF_OFS_STATUS, 32'h0);
    apb(1'b0, FSF_OFS_STATUS, 32'h0);
    `CHK(rd, 32'h0)
    // random frames over all parity modes; the first has a bad stop bit
    apb(1'b1, FSF_OFS_CONTROL, 32'h30);
    @(negedge pclk);
    `CHK({txe, rxe}, 2'b11)
    nerr = 8'h00;
    anyf = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      void'(rnd());
      md = {lfsr[9], 2'(i)};
      rxb[i] = 8'(lfsr);
      flt[i] = fault(8'(lfsr), lfsr[10], lfsr[11] && i != 0, md);
      apb(1'b1, FSF_OFS_MODE, 32'(md));
      p.send(8'(lfsr), lfsr[10], lfsr[11] && i != 0);
      nerr += 8'(|flt[i]);
      anyf |= |flt[i];
      chain = 1'b1;
      apb(1'b0, FSF_OFS_STATUS, 32'h0);
      `CHK(rd[7], anyf)
      `CHK(rd[15:8], nerr)
    end
    // fault bits follow the byte read out; the count falls
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, FSF_OFS_RXPORT, 32'h0);
      `CHK(rd, {24'h000000, rxb[i]})
      apb(1'b0, FSF_OFS_STATUS, 32'h0);
      nerr -= 8'(|flt[i]);
      `CHK(rd[3:2], flt[i])
      `CHK(rd[15:8], nerr)
    end
    apb(1'b1, FSF_OFS_STATUS, 32'h0);
    apb(1'b0, FSF_OFS_STATUS, 32'h0);
    `CHK(rd[7], 1'b0)
    p.send(8'h5a, 1'b0, 1'b0);
    apb(1'b1, FSF_OFS_CONTROL, 32'h20);
    @(negedge pclk);
    `CHK({txe, rxe}, 2'b10)
    apb(1'b0, FSF_OFS_STATUS, 32'h0);
    `CHK(rd[7], 1'b1)
    // trigger levels 4, 2, 1; level 2 after module standby, levels 4 and 1 after standby
    for (int k = 1; k < 4; k++)
    begin
      tl = 8 >> k;
      if (k == 2)
        module_standby <= 1'b1;
      else
        standby <= 1'b1;
      @(posedge pclk);
      standby <= 1'b0;
      module_standby <= 1'b0;
      chain = 1'b1;
      apb(1'b0, FSF_OFS_STATUS, 32'h0);
      `CHK(rd, 32'(FSF_STATUS_RST))
      apb(1'b1, FSF_OFS_CONTROL, 32'h20);
      apb(1'b1, FSF_OFS_FIFOCTL, 32'(k) << FSF_FCR_TTRG_LSB);
      for (int j = 0; j <= tl; j++)
        apb(1'b1, FSF_OFS_TXPORT, 32'(rnd()), j == tl);
      apb(1'b0, FSF_OFS_STATUS, 32'h0);
      `CHK(rd[6:5], 2'b00)
      p.shift(1);
      apb(1'b0, FSF_OFS_STATUS, 32'h0);
      `CHK(rd[5], 1'b0)
      p.shift(6);
      apb(1'b0, FSF_OFS_STATUS, 32'h0);
      `CHK(rd[6:5], {tl == 1, 1'b1})
      repeat (tl - 1) p.shift(2);
      apb(1'b0, FSF_OFS_STATUS, 32'h0);
      `CHK(rd[6], 1'b1)
      repeat (17) apb(1'b1, FSF_OFS_TXPORT, 32'(rnd()));
      apb(1'b0, FSF_OFS_TXPORT, 32'h0);
      `CHK(rd, 32'h10)
      apb(1'b1, FSF_OFS_CONTROL, 32'h0);
      apb(1'b0, FSF_OFS_STATUS, 32'h0);
      `CHK(rd[6], 1'b1)
    end
    results();
  end
  // the run needs a few hundred cycles; 100 us means a hang
  initial
  begin
    #100000;
    failures++;
    results();
  end
endmodule
